// ---- src/vsr_regs.v ----
/*
 * output voltage select and system control register pair of a step-down
 * converter controller, with switch enable and protection mode handling.
 * holds the two registers, the scaling-go handshake with its pending
 * reference command, the power state machine for enable, over-voltage and
 * over-current handling, and the registered read-back mux.
 * the scaling-go flag clears itself only after an accepted code write and
 * the ramp landing on that code; set with no code write, it stays set until a control write or shutdown.
 * a control write with the flag clear aborts the grant.
 * protection inputs trip the block only while switching; an over-voltage
 * wins over a current fault seen in the same cycle.
 * the ramp keeps tracking the code in the divider loop as well, so a change
 * to the digital loop starts from the programmed code with no slew.
 * assumes a serial-bus engine that delivers one write strobe per data byte,
 * with register and data bytes valid alongside it.
 * assumes protection comparators and the enable pin synchronous to clk_sys;
 * the enable pin low acts as a full clear of the block.
 */
`include "vsr_map.vh"

module vsr_regs (
    input wire clk_sys, // 40 MHz system clock
    input wire reset, // synchronous reset, active high
    input wire en_pin, // external enable pin level
    input wire wr_strobe, // one-cycle pulse at end of data byte
    input wire [7:0] wr_reg, // register byte of the write
    input wire [7:0] wr_data, // data byte of the write
    input wire [7:0] rd_reg, // register byte of a read
    input wire ovp_detect, // over_voltage_protection comparator
    input wire ocp_detect, // over_current_protection comparator
    input wire uvp_detect, // under_voltage_protection comparator
    output reg [7:0] rd_data_q, // read data for rd_reg
    output reg bus_active_q, // serial interface logic enabled
    output reg loop_digital_q, // 1 digital reference loop in charge
    output reg feedback_divider_sel_q, // 1 feedback_divider_input loop
    output reg [6:0] ref_code_q, // reference code to the loop DAC
    output reg forced_pwm_q, // 1 forced PWM, 0 auto PFM/PWM
    output reg high_side_switch_en_q, // high_side_switch may switch
    output reg low_side_switch_en_q, // low_side_switch may switch
    output reg hiccup_q, // hiccup off time running
    output reg latched_off_q // protection latch-off
);
    // power state codes
    localparam [4:0] ST_OFF = 5'b00001;
    localparam [4:0] ST_RUN = 5'b00010;
    localparam [4:0] ST_OVP_WAIT = 5'b00100;
    localparam [4:0] ST_HICCUP = 5'b01000;
    localparam [4:0] ST_LATCH = 5'b10000;

    // shutdown: reset or enable pin low clears every register
    wire shutdown = reset | ~en_pin;
    wire [31:0] hic_cyc = `VSR_HICCUP_OFF_CYC;

    // register reset words, cut into fields below
    wire [7:0] output_voltage_select_rst = `VSR_OUTPUT_VOLTAGE_SELECT_RESET;
    wire [7:0] ctl_rst = `VSR_CTL_RESET;

    // register fields
    reg output_voltage_select_loop_q;
    reg [6:0] output_voltage_select_code_q;
    reg ctl_en_q;
    reg ctl_go_q;
    reg [2:0] ctl_slew_q;
    reg ctl_retry_q;
    reg ctl_hiccup_q;
    reg ctl_mode_q;

    // scaling-go bookkeeping and power state
    reg cmd_pend_q;
    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [11:0] hic_cnt_q;

    // reference ramp outputs
    wire [6:0] ramp_code;
    wire ramp_done;

    // write decode, taken on the data byte strobe
    wire wr_output_voltage_select = wr_strobe & (wr_reg == `VSR_OFF_CONVERTER_OUTPUT_LEVEL_SEL);
    wire wr_ctl = wr_strobe & (wr_reg == `VSR_OFF_SYSCTL1);
    wire code_take = wr_output_voltage_select & ctl_go_q;
    wire go_set = wr_ctl & wr_data[`VSR_CTL_GO_BIT];
    // ramp settled on the code now in the register; the registered
    // at-target flag alone still reflects the previous target for a cycle
    wire ramp_landed = ramp_done & (ramp_code == output_voltage_select_code_q);
    wire go_done = cmd_pend_q & ramp_landed & ~code_take;
    wire fault_ocp = ocp_detect & uvp_detect;
    wire hic_end = (hic_cnt_q >= hic_cyc[11:0] - 12'h001); // off time used up

    // output voltage select register
    always @(posedge clk_sys) begin
        if (shutdown) begin
            output_voltage_select_loop_q <= output_voltage_select_rst[`VSR_OUTPUT_VOLTAGE_SELECT_LOOP_BIT];
            output_voltage_select_code_q <= output_voltage_select_rst[`VSR_OUTPUT_VOLTAGE_SELECT_CODE_MSB:`VSR_OUTPUT_VOLTAGE_SELECT_CODE_LSB];
        end else if (wr_output_voltage_select) begin
            output_voltage_select_loop_q <= wr_data[`VSR_OUTPUT_VOLTAGE_SELECT_LOOP_BIT];
            if (code_take) begin
                output_voltage_select_code_q <= wr_data[6:0];
            end
        end
    end

    // system control register, plain fields
    always @(posedge clk_sys) begin
        if (shutdown) begin
            ctl_en_q <= ctl_rst[`VSR_CTL_EN_BIT];
            ctl_slew_q <= ctl_rst[`VSR_CTL_SLEW_MSB:`VSR_CTL_SLEW_LSB];
            ctl_retry_q <= ctl_rst[`VSR_CTL_RETRY_BIT];
            ctl_hiccup_q <= ctl_rst[`VSR_CTL_HICCUP_BIT];
            ctl_mode_q <= ctl_rst[`VSR_CTL_MODE_BIT];
        end else if (wr_ctl) begin
            ctl_en_q <= wr_data[`VSR_CTL_EN_BIT];
            ctl_slew_q <= wr_data[`VSR_CTL_SLEW_MSB:`VSR_CTL_SLEW_LSB];
            ctl_retry_q <= wr_data[`VSR_CTL_RETRY_BIT];
            ctl_hiccup_q <= wr_data[`VSR_CTL_HICCUP_BIT];
            ctl_mode_q <= wr_data[`VSR_CTL_MODE_BIT];
        end
    end

    // scaling-go flag: host set wins over the self clear
    always @(posedge clk_sys) begin
        if (shutdown) begin
            ctl_go_q <= 1'b0;
        end else if (go_set) begin
            ctl_go_q <= 1'b1;
        end else if (go_done) begin
            ctl_go_q <= 1'b0;
        end else if (wr_ctl) begin
            ctl_go_q <= 1'b0;
        end
    end

    // pending reference command, armed by an accepted code write
    always @(posedge clk_sys) begin
        if (shutdown) begin
            cmd_pend_q <= 1'b0;
        end else if (code_take) begin
            cmd_pend_q <= 1'b1;
        end else if (go_done) begin
            cmd_pend_q <= 1'b0;
        end
    end

    // reference ramp toward the programmed code
    vsr_ref_ramp u_ramp (
        .clk_sys(clk_sys),
        .clear(shutdown),
        .target(output_voltage_select_code_q),
        .slew_sel(ctl_slew_q),
        .code_q(ramp_code),
        .at_target_q(ramp_done)
    );

    // power state next value
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (ctl_en_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!ctl_en_q) begin
                    state_d = ST_OFF;
                end else if (ovp_detect && ctl_retry_q) begin
                    state_d = ST_OVP_WAIT;
                end else if (ovp_detect) begin
                    state_d = ST_LATCH;
                end else if (fault_ocp && ctl_hiccup_q) begin
                    state_d = ST_HICCUP;
                end else if (fault_ocp) begin
                    state_d = ST_LATCH;
                end
            end
            ST_OVP_WAIT: begin
                if (!ovp_detect) begin
                    state_d = ctl_en_q ? ST_RUN : ST_OFF;
                end
            end
            ST_HICCUP: begin
                if (hic_end) begin
                    state_d = ctl_en_q ? ST_RUN : ST_OFF;
                end
            end
            ST_LATCH: begin
                state_d = ST_LATCH;
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
    end

    // power state register
    always @(posedge clk_sys) begin
        if (shutdown) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // hiccup off-time counter, runs only in the hiccup state
    always @(posedge clk_sys) begin
        if (shutdown) begin
            hic_cnt_q <= 12'h000;
        end else if (state_q == ST_HICCUP) begin
            hic_cnt_q <= hic_cnt_q + 12'h001;
        end else begin
            hic_cnt_q <= 12'h000;
        end
    end

    // loop selection, reference and light-load mode outputs
    always @(posedge clk_sys) begin
        if (shutdown) begin
            loop_digital_q <= 1'b0;
            feedback_divider_sel_q <= 1'b1;
            ref_code_q <= `VSR_FB_REF_CODE;
            forced_pwm_q <= 1'b0;
        end else begin
            loop_digital_q <= ~output_voltage_select_loop_q;
            feedback_divider_sel_q <= output_voltage_select_loop_q;
            if (output_voltage_select_loop_q) begin
                ref_code_q <= `VSR_FB_REF_CODE;
            end else begin
                ref_code_q <= ramp_code;
            end
            forced_pwm_q <= ctl_go_q | ctl_mode_q;
        end
    end

    // switch enables, high only while running
    always @(posedge clk_sys) begin
        if (shutdown) begin
            high_side_switch_en_q <= 1'b0;
            low_side_switch_en_q <= 1'b0;
        end else begin
            high_side_switch_en_q <= (state_d == ST_RUN);
            low_side_switch_en_q <= (state_d == ST_RUN);
        end
    end

    // protection status
    always @(posedge clk_sys) begin
        if (shutdown) begin
            hiccup_q <= 1'b0;
            latched_off_q <= 1'b0;
        end else begin
            hiccup_q <= (state_d == ST_HICCUP);
            latched_off_q <= (state_d == ST_LATCH);
        end
    end

    // serial interface enable follows the enable pin
    always @(posedge clk_sys) begin
        if (reset) begin
            bus_active_q <= 1'b0;
        end else begin
            bus_active_q <= en_pin;
        end
    end

    // read data mux, registered; unmapped and shut-down reads give zero
    always @(posedge clk_sys) begin
        if (shutdown) begin
            rd_data_q <= 8'h00;
        end else begin
            case (rd_reg)
                `VSR_OFF_CONVERTER_OUTPUT_LEVEL_SEL: begin
                    rd_data_q <= {output_voltage_select_loop_q, output_voltage_select_code_q};
                end
                `VSR_OFF_SYSCTL1: begin
                    rd_data_q <= {ctl_en_q, ctl_go_q, ctl_slew_q,
                        ctl_retry_q, ctl_hiccup_q, ctl_mode_q};
                end
                default: begin
                    rd_data_q <= 8'h00;
                end
            endcase
        end
    end
endmodule // vsr_regs

// ---- src/vsr_map.vh ----
/*
 * constants for the output voltage select and system control register pair:
 * offsets, field positions, reset values and timing counts.
 * assumes a 40 MHz system clock and inclusion by bare name.
 */
`ifndef VSR_MAP_VH
`define VSR_MAP_VH

// register offsets as seen on the register write port
`define VSR_OFF_CONVERTER_OUTPUT_LEVEL_SEL 8'h00
`define VSR_OFF_SYSCTL1 8'h01

// output_voltage_select fields
`define VSR_OUTPUT_VOLTAGE_SELECT_LOOP_BIT 7
`define VSR_OUTPUT_VOLTAGE_SELECT_CODE_MSB 6
`define VSR_OUTPUT_VOLTAGE_SELECT_CODE_LSB 0

// system_control_one fields
`define VSR_CTL_EN_BIT 7
`define VSR_CTL_GO_BIT 6
`define VSR_CTL_SLEW_MSB 5
`define VSR_CTL_SLEW_LSB 3
`define VSR_CTL_RETRY_BIT 2
`define VSR_CTL_HICCUP_BIT 1
`define VSR_CTL_MODE_BIT 0

// reset values
`define VSR_OUTPUT_VOLTAGE_SELECT_RESET 8'h9E
`define VSR_CTL_RESET 8'hA6

// fixed reference of the feedback divider loop, 0.60 V
`define VSR_FB_REF_CODE 7'h00

// clock and timing figures
`define VSR_CLK_PERIOD_NS 25
`define VSR_SLEW_BASE_NS 500
`define VSR_SLEW_BASE_CYC ((`VSR_SLEW_BASE_NS + `VSR_CLK_PERIOD_NS - 1) / `VSR_CLK_PERIOD_NS)
`define VSR_HICCUP_OFF_NS 100000
`define VSR_HICCUP_OFF_CYC (`VSR_HICCUP_OFF_NS / `VSR_CLK_PERIOD_NS)

`endif

// ---- src/vsr_ref_ramp.v ----
/*
 * reference ramp: walks the internal reference code toward the target one
 * step at a time, at an interval set by the 3-bit slew select.
 * assumes a synchronous active-high clear and one system clock.
 */
`include "vsr_map.vh"

module vsr_ref_ramp (
    input wire clk_sys, // system clock
    input wire clear, // synchronous clear, loads the reset code
    input wire [6:0] target, // code to move toward
    input wire [2:0] slew_sel, // interval select
    output reg [6:0] code_q, // present reference code
    output reg at_target_q // code equals target
);
    wire [31:0] base_cyc = `VSR_SLEW_BASE_CYC;
    wire [11:0] interval = base_cyc[11:0] << slew_sel;
    reg [11:0] tick_q;
    wire [7:0] code_rst = `VSR_OUTPUT_VOLTAGE_SELECT_RESET; // code field sits in bits 6:0

    // one code step per elapsed interval
    always @(posedge clk_sys) begin
        if (clear) begin
            code_q <= code_rst[6:0];
            tick_q <= 12'h000;
            at_target_q <= 1'b1;
        end else begin
            at_target_q <= (code_q == target);
            if (code_q == target) begin
                tick_q <= 12'h000;
            end else if (tick_q >= interval - 12'h001) begin
                tick_q <= 12'h000;
                if (code_q < target) begin
                    code_q <= code_q + 7'h01;
                end else begin
                    code_q <= code_q - 7'h01;
                end
            end else begin
                tick_q <= tick_q + 12'h001;
            end
        end
    end
endmodule // vsr_ref_ramp

// ---- testbench/vsr_regs_props.sv ----
/*
 * assertions on the ports of vsr_regs.
 * assumes binding from the bench top and one clock domain.
 */
module vsr_regs_props (
    input wire clk_sys, // clock
    input wire reset, // sync reset
    input wire en_pin, // enable pin
    input wire ovp_detect, // over-voltage
    input wire ocp_detect, // over-current
    input wire uvp_detect, // under-voltage
    input wire [7:0] rd_data_q, // read data
    input wire bus_active_q, // bus logic on
    input wire loop_digital_q, // digital loop
    input wire feedback_divider_sel_q, // divider loop
    input wire [6:0] ref_code_q, // dac code
    input wire high_side_switch_en_q, // high switch
    input wire low_side_switch_en_q, // low switch
    input wire hiccup_q, // hiccup running
    input wire latched_off_q // latched off
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // over-current with under-voltage while running
    sequence s_cu_fault;
        en_pin && high_side_switch_en_q && ocp_detect && uvp_detect && !ovp_detect;
    endsequence
    // port relations
    reset_state_a: assert property (disable iff (1'b0) reset |=>
        feedback_divider_sel_q && !loop_digital_q && ref_code_q == 7'h00
        && !high_side_switch_en_q) else $error("reset state wrong");
    loop_excl_a: assert property (feedback_divider_sel_q != loop_digital_q)
        else $error("loop selects disagree");
    div_ref_a: assert property (feedback_divider_sel_q && $past(feedback_divider_sel_q)
        |-> ref_code_q == 7'h00) else $error("divider loop code not zero");
    bus_track_a: assert property (en_pin |=> bus_active_q)
        else $error("bus not active");
    pin_off_a: assert property (!en_pin |=> !bus_active_q && !high_side_switch_en_q
        && rd_data_q == 8'h00) else $error("pin low not shut down");
    sw_pair_a: assert property (high_side_switch_en_q == low_side_switch_en_q)
        else $error("switch enables differ");
    ovp_trip_a: assert property (en_pin && high_side_switch_en_q && ovp_detect
        |=> !high_side_switch_en_q) else $error("over-voltage not stopped");
    latch_hold_a: assert property (latched_off_q && en_pin
        |=> latched_off_q && !high_side_switch_en_q) else $error("latch released");
    cu_fault_a: assert property (s_cu_fault |=> !high_side_switch_en_q
        ##[0:1] (hiccup_q || latched_off_q)) else $error("current fault missed");
    hiccup_len_a: assert property ($rose(hiccup_q) |-> hiccup_q [*8])
        else $error("hiccup too short");
    ramp_step_a: assert property (loop_digital_q && $past(loop_digital_q)
        && $past(en_pin) && !$stable(ref_code_q) |-> ref_code_q == $past(ref_code_q)
        + 7'h01 || ref_code_q == $past(ref_code_q) - 7'h01) else $error("ramp jumped");
endmodule // vsr_regs_props

// ---- testbench/vsr_host.sv ----
/*
 * serial-bus host model: register writes and reads.
 * assumes the bench calls its tasks; drives at falling edges.
 */
module vsr_host (
    input wire clk_sys, // clock
    input wire [7:0] rd_data_q, // read data
    output logic wr_strobe, // write pulse
    output logic [7:0] wr_reg, // register byte
    output logic [7:0] wr_data, // data byte
    output logic [7:0] rd_reg // read select
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus
    initial begin
        wr_strobe = 1'b0;
        wr_reg = 8'hFF;
        wr_data = 8'h00;
        rd_reg = 8'h00;
    end
    // one byte write, strobe over one rising edge
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        @(negedge clk_sys);
        wr_reg = r;
        wr_data = d;
        wr_strobe = 1'b1;
        @(negedge clk_sys);
        wr_strobe = 1'b0;
        wr_reg = ~r; // no stale byte after release
        wr_data = ~d;
    endtask
    // read: select, then sample one edge later
    task automatic rd(input logic [7:0] r, output logic [7:0] d);
        @(negedge clk_sys);
        rd_reg = r;
        @(negedge clk_sys);
        d = rd_data_q;
    endtask
    // grant first, then the new code
    task automatic scale(input logic [7:0] ctl, input logic [7:0] code);
        wr(8'h01, ctl);
        wr(8'h00, code);
    endtask
endmodule // vsr_host

// ---- testbench/vsr_regs_tb.sv ----
/*
 * self-checking bench for vsr_regs.
 * assumes vsr_host as bus master and the props checker bound below.
 */
module vsr_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic en_pin = 1'b1;
    logic ovp_detect = 1'b0;
    logic ocp_detect = 1'b0;
    logic uvp_detect = 1'b0;
    wire wr_strobe, bus_active_q, loop_digital_q, feedback_divider_sel_q, forced_pwm_q;
    wire high_side_switch_en_q, low_side_switch_en_q, hiccup_q, latched_off_q;
    wire [7:0] wr_reg, wr_data, rd_reg, rd_data_q;
    wire [6:0] ref_code_q;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    logic [7:0] v;
    vsr_regs uut (.clk_sys(clk_sys), .reset(reset), .en_pin(en_pin),
        .wr_strobe(wr_strobe), .wr_reg(wr_reg), .wr_data(wr_data), .rd_reg(rd_reg),
        .ovp_detect(ovp_detect), .ocp_detect(ocp_detect), .uvp_detect(uvp_detect),
        .rd_data_q(rd_data_q), .bus_active_q(bus_active_q),
        .loop_digital_q(loop_digital_q), .feedback_divider_sel_q(feedback_divider_sel_q),
        .ref_code_q(ref_code_q), .forced_pwm_q(forced_pwm_q),
        .high_side_switch_en_q(high_side_switch_en_q),
        .low_side_switch_en_q(low_side_switch_en_q), .hiccup_q(hiccup_q),
        .latched_off_q(latched_off_q));
    vsr_host host (.clk_sys(clk_sys), .rd_data_q(rd_data_q), .wr_strobe(wr_strobe),
        .wr_reg(wr_reg), .wr_data(wr_data), .rd_reg(rd_reg));
    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            close_out();
        end
    end
    // compare and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic idle(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    // scale to a code and poll the grant until it clears
    task automatic ramp(input logic [2:0] sel, input logic [6:0] code);
        int iv;
        iv = 20 << sel;
        host.scale({2'b11, sel, 3'b110}, {1'b0, code});
        chk("pwm_go", {7'h00, forced_pwm_q}, 8'h01);
        host.rd(8'h01, v);
        n = 0;
        while (v[6] !== 1'b0 && n < 6000) begin
            @(negedge clk_sys);
            v = rd_data_q;
            n++;
        end
        chk("ref_code", {1'b0, ref_code_q}, {1'b0, code});
        chk("pwm_back", {7'h00, forced_pwm_q}, 8'h00);
        chk("ramp_len", {7'h00, n >= iv && n <= 2 * iv + 8}, 8'h01);
    endtask
    // main sequence
    initial begin
        idle(3);
        reset = 1'b0;
        chk("div_sel", {7'h00, feedback_divider_sel_q}, 8'h01);
        host.rd(8'h00, v);
        chk("output_voltage_select_rst", v, 8'h9E);
        host.rd(8'h01, v);
        chk("ctl_rst", v, 8'hA6);
        host.rd(8'h02, v);
        chk("unmapped", v, 8'h00);
        chk("sw_on", {7'h00, high_side_switch_en_q}, 8'h01);
        host.wr(8'h00, 8'h05);
        host.rd(8'h00, v);
        chk("no_grant", v, 8'h1E);
        chk("digital", {7'h00, loop_digital_q}, 8'h01);
        for (int i = 0; i < 8; i++)
            ramp(i[2:0], i[0] ? 7'h1E : 7'h20);
        host.wr(8'h00, 8'h10);
        host.rd(8'h00, v);
        chk("grant_gone", v, 8'h1E);
        host.wr(8'h01, 8'h87);
        idle(2);
        chk("mode_pwm", {7'h00, forced_pwm_q}, 8'h01);
        host.wr(8'h01, 8'h06);
        idle(3);
        chk("en_off", {7'h00, high_side_switch_en_q}, 8'h00);
        host.wr(8'h01, 8'h86);
        idle(3);
        chk("en_on", {7'h00, high_side_switch_en_q}, 8'h01);
        ovp_detect = 1'b1;
        idle(3);
        chk("ovp_off", {7'h00, high_side_switch_en_q}, 8'h00);
        ovp_detect = 1'b0;
        idle(3);
        chk("ovp_back", {6'h00, latched_off_q, high_side_switch_en_q}, 8'h01);
        ocp_detect = 1'b1;
        uvp_detect = 1'b1;
        idle(2);
        ocp_detect = 1'b0;
        uvp_detect = 1'b0;
        chk("hiccup", {7'h00, hiccup_q}, 8'h01);
        n = 0;
        while (high_side_switch_en_q !== 1'b1 && n < 5000) begin
            idle(1);
            n++;
        end
        chk("hiccup_len", {7'h00, n > 3980 && n < 4010}, 8'h01);
        host.wr(8'h01, 8'h80);
        ovp_detect = 1'b1;
        idle(2);
        ovp_detect = 1'b0;
        idle(5);
        chk("ovp_latch", {6'h00, latched_off_q, high_side_switch_en_q}, 8'h02);
        en_pin = 1'b0;
        idle(2);
        chk("pin_low", {6'h00, latched_off_q, bus_active_q}, 8'h00);
        en_pin = 1'b1;
        idle(3);
        host.rd(8'h00, v);
        chk("restart", v, 8'h9E);
        host.wr(8'h01, 8'h80);
        idle(3);
        ocp_detect = 1'b1;
        uvp_detect = 1'b1;
        idle(3);
        ocp_detect = 1'b0;
        uvp_detect = 1'b0;
        chk("ocp_latch", {6'h00, latched_off_q, hiccup_q}, 8'h02);
        close_out();
    end
endmodule // vsr_regs_tb

bind vsr_regs vsr_regs_props props_i (.*);
